// *** rtl/nvm_ctrl_pkg.sv ***
// Shared constants and carrier types for the self-write memory control block.
// Assumes a 50 MHz core clock and a 32-bit classic Wishbone register slave.
package nvm_ctrl_pkg;

   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_UNLOCK = 8'h04;
   localparam logic [7:0] OFF_LATCH = 8'h08;
   localparam logic [7:0] OFF_PTR_U = 8'h0C;
   localparam logic [7:0] OFF_PTR_H = 8'h10;
   localparam logic [7:0] OFF_PTR_L = 8'h14;
   localparam logic [7:0] OFF_DONE = 8'h18;
   localparam logic [7:0] OFF_TBL_OP = 8'h1C;
   localparam logic [7:0] OFF_EE_ADDR = 8'h20;
   localparam logic [7:0] OFF_EE_DATA = 8'h24;

   // Control register field positions.
   localparam int B_MEMSEL = 7;
   localparam int B_CFGSEL = 6;
   localparam int B_ERASE = 4;
   localparam int B_WERR = 3;
   localparam int B_WRITE_PERMIT = 2;
   localparam int B_WR = 1;
   localparam int B_RD = 0;

   // Table operation register field positions.
   localparam int B_TBL_STORE = 2;
   localparam int B_TBL_MODE = 0;

   // Unlock sequence bytes and tracker states.
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [1:0] UNL_IDLE = 2'h0;
   localparam logic [1:0] UNL_HALF = 2'h1;
   localparam logic [1:0] UNL_OPEN = 2'h3;

   // Pointer geometry.
   localparam int PTR_W = 22;
   localparam int PTR_LOW_W = 21;
   localparam int UPPER_W = 6;
   localparam int HOLD_IDX_W = 3;
   localparam int ERASE_LSB = 6;

   // Programming timer: time in microseconds, cycles derived from the clock rate.
   localparam int PROG_TIME_US = 2000;
   localparam int CLK_FREQ_MHZ = 50;
   localparam int CNT_W = 17;
   localparam logic [CNT_W-1:0] PROG_CYCLES_DEF = CNT_W'(PROG_TIME_US * CLK_FREQ_MHZ);

   // Pointer update modes of a table instruction.
   typedef enum logic [1:0] {
      PTR_KEEP = 2'h0,
      PTR_POST_INC = 2'h1,
      PTR_POST_DEC = 2'h2,
      PTR_PRE_INC = 2'h3
   } ptr_mode_t;

   // Space addressed by an access.
   typedef enum logic [1:0] {
      SPACE_EEPROM = 2'h0,
      SPACE_FLASH = 2'h1,
      SPACE_CONFIG = 2'h2
   } space_t;

   // Command bundle toward the nonvolatile arrays.
   typedef struct packed {
      logic prog_start;
      logic erase_start;
      logic ee_read;
      logic abort;
      space_t space;
      logic [PTR_W-1:0] addr;
      logic [63:0] wdata;
   } nv_cmd_t;

endpackage : nvm_ctrl_pkg

// *** rtl/tbl_ptr_step.sv ***
// Pointer arithmetic for table fetch and store instructions.
// Assumes the caller registers both results; this leaf holds no state.
`timescale 1ns/10ps
module tbl_ptr_step (
   input wire logic [nvm_ctrl_pkg::PTR_W-1:0] ptr_i,
   input wire nvm_ctrl_pkg::ptr_mode_t mode_i,
   output logic [nvm_ctrl_pkg::PTR_W-1:0] access_o,
   output logic [nvm_ctrl_pkg::PTR_W-1:0] next_o
);

   logic [nvm_ctrl_pkg::PTR_LOW_W-1:0] low_inc;
   logic [nvm_ctrl_pkg::PTR_LOW_W-1:0] low_dec;
   logic top_bit;

   // Only the low bits wrap; the space bit rides along untouched.
   always_comb begin
      top_bit = ptr_i[nvm_ctrl_pkg::PTR_W-1];
      low_inc = ptr_i[nvm_ctrl_pkg::PTR_LOW_W-1:0] + 1'b1;
      low_dec = ptr_i[nvm_ctrl_pkg::PTR_LOW_W-1:0] - 1'b1;
      access_o = ptr_i;
      next_o = ptr_i;
      case (mode_i)
         nvm_ctrl_pkg::PTR_KEEP: begin
            next_o = ptr_i;
         end
         nvm_ctrl_pkg::PTR_POST_INC: begin
            next_o = {top_bit, low_inc};
         end
         nvm_ctrl_pkg::PTR_POST_DEC: begin
            next_o = {top_bit, low_dec};
         end
         nvm_ctrl_pkg::PTR_PRE_INC: begin
            access_o = {top_bit, low_inc};
            next_o = {top_bit, low_inc};
         end
         default: begin
            next_o = ptr_i;
         end
      endcase
   end

endmodule : tbl_ptr_step

// *** rtl/nvm_access_ctrl.sv ***
// Self-write memory control: control, unlock, latch and pointer registers,
// table instructions, holding registers and the self-timed programming cycle.
// Assumes a classic Wishbone master on the core clock and arrays that answer
// a word or byte combinationally to the registered command address.
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/10ps
module nvm_access_ctrl #(
   parameter logic [nvm_ctrl_pkg::CNT_W-1:0] PROG_CYCLES = nvm_ctrl_pkg::PROG_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] flash_word_i,
   input wire logic [7:0] eeprom_byte_i,
   input wire logic master_clear_reset_i,
   input wire logic watchdog_reset_i,
   output nvm_ctrl_pkg::nv_cmd_t nv_cmd_o,
   output logic cpu_stall_o,
   output logic nonvolatile_done_irq_flag_o
);

   // Table instruction sequencer states, Gray along idle, address, data.
   typedef enum logic [1:0] {
      TBL_IDLE = 2'b00,
      TBL_ADDR = 2'b01,
      TBL_DATA = 2'b11
   } tbl_state_t;

   typedef struct packed {
      logic memsel;
      logic cfgsel;
      logic erase_sel;
      logic werr;
      logic write_permit;
      logic wr;
      logic rd;
      logic erasing;
      logic [1:0] unlock;
      logic [7:0] latch;
      logic [nvm_ctrl_pkg::UPPER_W-1:0] ptr_u;
      logic [7:0] ptr_h;
      logic [7:0] ptr_l;
      logic [7:0] ee_addr;
      logic [7:0] ee_data;
      logic done_flag;
      logic [7:0][7:0] hold;
      logic [nvm_ctrl_pkg::CNT_W-1:0] timer;
      tbl_state_t tstate;
      logic tstore;
      nvm_ctrl_pkg::ptr_mode_t tmode;
      logic ack;
      logic [31:0] rdat;
      nvm_ctrl_pkg::nv_cmd_t cmd;
      logic stall;
      logic [1:0] master_clear_reset_sync;
   } state_t;

   state_t q;
   state_t d;
   logic [nvm_ctrl_pkg::PTR_W-1:0] ptr_full;
   logic [nvm_ctrl_pkg::PTR_W-1:0] ptr_access;
   logic [nvm_ctrl_pkg::PTR_W-1:0] ptr_next;
   logic accept;
   logic abort_now;
   logic wr_byte;
   logic [7:0] wbyte;
   logic [7:0] ctrl_view;
   nvm_ctrl_pkg::space_t space_sel;

   // Concatenated pointer and the space that the select bits point at.
   assign ptr_full = {q.ptr_u, q.ptr_h, q.ptr_l};
   assign space_sel = q.cfgsel ? nvm_ctrl_pkg::SPACE_CONFIG :
                      (q.memsel ? nvm_ctrl_pkg::SPACE_FLASH : nvm_ctrl_pkg::SPACE_EEPROM);
   assign accept = wb_cyc_i & wb_stb_i & ~q.ack & (q.tstate == TBL_IDLE) & ~q.stall;
   assign abort_now = q.master_clear_reset_sync[1] | watchdog_reset_i;
   assign wr_byte = wb_we_i & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];
   assign ctrl_view = {q.memsel, q.cfgsel, 1'b0, q.erase_sel, q.werr, q.write_permit, q.wr, q.rd};

   tbl_ptr_step u_step (
      .ptr_i(ptr_full),
      .mode_i(q.tmode),
      .access_o(ptr_access),
      .next_o(ptr_next)
   );

   // Outputs come straight from state flip-flops.
   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign nv_cmd_o = q.cmd;
   assign cpu_stall_o = q.stall;
   assign nonvolatile_done_irq_flag_o = q.done_flag;

   // Next-state logic; later sections take priority over earlier ones.
   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.cmd.prog_start = 1'b0;
      d.cmd.erase_start = 1'b0;
      d.cmd.ee_read = 1'b0;
      d.cmd.abort = 1'b0;
      d.master_clear_reset_sync = {q.master_clear_reset_sync[0], master_clear_reset_i};

      // An EEPROM read lasts one cycle, then the byte lands in the data register.
      if (q.rd) begin
         d.rd = 1'b0;
         d.ee_data = eeprom_byte_i;
      end

      // Table instruction sequencer.
      case (q.tstate)
         TBL_IDLE: begin
            d.tstate = TBL_IDLE;
         end
         TBL_ADDR: begin
            d.cmd.addr = ptr_access;
            d.cmd.space = nvm_ctrl_pkg::SPACE_FLASH;
            {d.ptr_u, d.ptr_h, d.ptr_l} = ptr_next;
            if (q.tstore) begin
               d.hold[ptr_access[nvm_ctrl_pkg::HOLD_IDX_W-1:0]] = q.latch;
            end
            d.tstate = TBL_DATA;
         end
         TBL_DATA: begin
            if (!q.tstore) begin
               d.latch = q.cmd.addr[0] ? flash_word_i[15:8] : flash_word_i[7:0];
            end
            d.ack = 1'b1;
            d.tstate = TBL_IDLE;
         end
         default: begin
            d.tstate = TBL_IDLE;
         end
      endcase

      // Register slave: reads are captured, writes take effect when acknowledged.
      if (accept) begin
         d.ack = 1'b1;
         d.rdat = 32'h0000_0000;
         case (wb_adr_i)
            nvm_ctrl_pkg::OFF_CTRL: begin
               d.rdat[7:0] = ctrl_view;
               if (wr_byte) begin
                  d.memsel = wbyte[nvm_ctrl_pkg::B_MEMSEL];
                  d.cfgsel = wbyte[nvm_ctrl_pkg::B_CFGSEL];
                  d.erase_sel = wbyte[nvm_ctrl_pkg::B_ERASE];
                  d.werr = wbyte[nvm_ctrl_pkg::B_WERR];
                  d.write_permit = wbyte[nvm_ctrl_pkg::B_WRITE_PERMIT];
                  if (wbyte[nvm_ctrl_pkg::B_RD] && !wbyte[nvm_ctrl_pkg::B_MEMSEL]
                      && !q.wr) begin
                     d.rd = 1'b1;
                     d.cmd.ee_read = 1'b1;
                     d.cmd.space = wbyte[nvm_ctrl_pkg::B_CFGSEL] ?
                                   nvm_ctrl_pkg::SPACE_CONFIG : nvm_ctrl_pkg::SPACE_EEPROM;
                     d.cmd.addr = {14'h0000, q.ee_addr};
                  end
                  if (wbyte[nvm_ctrl_pkg::B_WR] && !q.wr) begin
                     d.unlock = nvm_ctrl_pkg::UNL_IDLE;
                     if (q.write_permit && q.unlock == nvm_ctrl_pkg::UNL_OPEN) begin
                        d.wr = 1'b1;
                        d.timer = PROG_CYCLES;
                        d.cmd.space = wbyte[nvm_ctrl_pkg::B_CFGSEL] ?
                                      nvm_ctrl_pkg::SPACE_CONFIG :
                                      (wbyte[nvm_ctrl_pkg::B_MEMSEL] ?
                                       nvm_ctrl_pkg::SPACE_FLASH : nvm_ctrl_pkg::SPACE_EEPROM);
                        if (wbyte[nvm_ctrl_pkg::B_MEMSEL] || wbyte[nvm_ctrl_pkg::B_CFGSEL]) begin
                           d.stall = 1'b1;
                           if (wbyte[nvm_ctrl_pkg::B_ERASE]) begin
                              d.erasing = 1'b1;
                              d.cmd.erase_start = 1'b1;
                              d.cmd.addr = {ptr_full[nvm_ctrl_pkg::PTR_W-1:nvm_ctrl_pkg::ERASE_LSB],
                                            6'h00};
                           end else begin
                              d.cmd.prog_start = 1'b1;
                              d.cmd.addr = {ptr_full[nvm_ctrl_pkg::PTR_W-1:nvm_ctrl_pkg::HOLD_IDX_W],
                                            3'h0};
                              d.cmd.wdata = q.hold;
                           end
                        end else begin
                           d.cmd.prog_start = 1'b1;
                           d.cmd.addr = {14'h0000, q.ee_addr};
                           d.cmd.wdata = {56'h0, q.ee_data};
                        end
                     end
                  end
               end
            end
            nvm_ctrl_pkg::OFF_UNLOCK: begin
               d.rdat = 32'h0000_0000;
               if (wr_byte) begin
                  if (wbyte == nvm_ctrl_pkg::UNLOCK_KEY1) begin
                     d.unlock = nvm_ctrl_pkg::UNL_HALF;
                  end else if (wbyte == nvm_ctrl_pkg::UNLOCK_KEY2 &&
                               q.unlock == nvm_ctrl_pkg::UNL_HALF) begin
                     d.unlock = nvm_ctrl_pkg::UNL_OPEN;
                  end else begin
                     d.unlock = nvm_ctrl_pkg::UNL_IDLE;
                  end
               end
            end
            nvm_ctrl_pkg::OFF_LATCH: begin
               d.rdat[7:0] = q.latch;
               if (wr_byte) begin
                  d.latch = wbyte;
               end
            end
            nvm_ctrl_pkg::OFF_PTR_U: begin
               d.rdat[nvm_ctrl_pkg::UPPER_W-1:0] = q.ptr_u;
               if (wr_byte) begin
                  d.ptr_u = wbyte[nvm_ctrl_pkg::UPPER_W-1:0];
               end
            end
            nvm_ctrl_pkg::OFF_PTR_H: begin
               d.rdat[7:0] = q.ptr_h;
               if (wr_byte) begin
                  d.ptr_h = wbyte;
               end
            end
            nvm_ctrl_pkg::OFF_PTR_L: begin
               d.rdat[7:0] = q.ptr_l;
               if (wr_byte) begin
                  d.ptr_l = wbyte;
               end
            end
            nvm_ctrl_pkg::OFF_DONE: begin
               d.rdat[0] = q.done_flag;
               if (wr_byte && !wbyte[0]) begin
                  d.done_flag = 1'b0;
               end
            end
            nvm_ctrl_pkg::OFF_TBL_OP: begin
               d.rdat[2:0] = {q.tstore, q.tmode};
               if (wr_byte) begin
                  d.ack = 1'b0;
                  d.tstore = wbyte[nvm_ctrl_pkg::B_TBL_STORE];
                  d.tmode = nvm_ctrl_pkg::ptr_mode_t'(wbyte[nvm_ctrl_pkg::B_TBL_MODE +: 2]);
                  d.tstate = TBL_ADDR;
               end
            end
            nvm_ctrl_pkg::OFF_EE_ADDR: begin
               d.rdat[7:0] = q.ee_addr;
               if (wr_byte) begin
                  d.ee_addr = wbyte;
               end
            end
            nvm_ctrl_pkg::OFF_EE_DATA: begin
               d.rdat[7:0] = q.ee_data;
               if (wr_byte) begin
                  d.ee_data = wbyte;
               end
            end
            default: begin
               d.rdat = 32'h0000_0000;
            end
         endcase
      end

      // Self-timed cycle; completion sets the done flag after any clear above.
      if (q.wr) begin
         if (q.timer <= 1) begin
            d.wr = 1'b0;
            d.werr = 1'b0;
            d.stall = 1'b0;
            d.done_flag = 1'b1;
            d.erasing = 1'b0;
            if (q.erasing) begin
               d.erase_sel = 1'b0;
            end
         end else begin
            d.timer = q.timer - 1'b1;
         end
      end

      // Master clear or watchdog reset: abort any cycle, keep the space selects.
      if (abort_now) begin
         if (q.wr) begin
            d.werr = 1'b1;
            d.cmd.abort = 1'b1;
         end
         d.memsel = q.memsel;
         d.cfgsel = q.cfgsel;
         d.wr = 1'b0;
         d.rd = 1'b0;
         d.erase_sel = 1'b0;
         d.write_permit = 1'b0;
         d.erasing = 1'b0;
         d.stall = 1'b0;
         d.timer = '0;
         d.unlock = nvm_ctrl_pkg::UNL_IDLE;
         d.ee_addr = 8'h00;
         d.ee_data = 8'h00;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_unlock_reads_zero:
   assert property (wb_ack_o && !wb_we_i && wb_adr_i == nvm_ctrl_pkg::OFF_UNLOCK
                    && q.tstate == TBL_IDLE |-> wb_dat_o == 32'h0000_0000)
      else $error("unlock port read returned nonzero data");

   a_bit5_reads_zero:
   assert property (wb_ack_o && !wb_we_i && wb_adr_i == nvm_ctrl_pkg::OFF_CTRL
                    |-> wb_dat_o[5] == 1'b0)
      else $error("control bit 5 read as one");

   a_read_one_cycle:
   assert property ($rose(q.rd) |=> !q.rd && q.ee_data == $past(eeprom_byte_i))
      else $error("read go did not finish in one cycle");

   a_read_refused_flash:
   assert property ($rose(q.rd) |-> !q.memsel)
      else $error("read go set while flash selected");

   a_launch_needs_unlock:
   assert property ($rose(q.wr) |-> $past(q.write_permit) && $past(q.unlock) == nvm_ctrl_pkg::UNL_OPEN)
      else $error("cycle launched without permit or unlock");

   a_cycle_length:
   assert property (q.wr && q.timer > 1 && !abort_now |=> q.wr && $past(q.timer) == q.timer + 1)
      else $error("programming cycle length wrong");

   a_done_sets_flag:
   assert property (q.wr && q.timer <= 1 && !abort_now |=> q.done_flag && !q.wr && !q.werr)
      else $error("completion did not raise done flag");

   a_abort_sets_error:
   assert property (q.wr && abort_now |=> q.werr && !q.wr && q.cmd.abort)
      else $error("aborted cycle did not flag write error");

   a_abort_keeps_select:
   assert property (q.wr && abort_now |=> $stable(q.memsel) && $stable(q.cfgsel))
      else $error("write error disturbed the space selects");

   a_erase_self_clears:
   assert property (q.wr && q.erasing && q.timer <= 1 |=> !q.erase_sel)
      else $error("erase select not cleared after erase");

   a_flash_stalls_core:
   assert property ($rose(q.wr) && space_sel != nvm_ctrl_pkg::SPACE_EEPROM
                    |-> q.stall throughout (q.wr [*2]))
      else $error("core not stalled during long write");

   a_top_bit_kept:
   assert property (q.tstate == TBL_ADDR |=> ptr_full[nvm_ctrl_pkg::PTR_W-1]
                    == $past(ptr_full[nvm_ctrl_pkg::PTR_W-1]))
      else $error("table update changed the space bit");

   a_table_op_acks:
   assert property (q.tstate == TBL_ADDR |-> ##1 q.tstate == TBL_DATA ##1 wb_ack_o)
      else $error("table operation did not complete in two cycles");

endmodule : nvm_access_ctrl

// *** testbench/nvm_array_model.sv ***
// Array model: flash word and EEPROM byte for the command address.
// Assumes the control block holds nv_cmd_o.addr until its next command.
`timescale 1ns/10ps
module nvm_array_model (
   input wire nvm_ctrl_pkg::nv_cmd_t cmd_i,
   output logic [15:0] flash_word_o,
   output logic [7:0] eeprom_byte_o
);
   // Every address bit except 17 to 20 shapes the contents, so a dropped bit among them shows up.
   always_comb begin
      flash_word_o = {cmd_i.addr[8:1] ^ 8'h5A, cmd_i.addr[21] ^ cmd_i.addr[16], cmd_i.addr[15:9]};
      eeprom_byte_o = cmd_i.addr[7:0] ^ 8'hC3;
   end
endmodule : nvm_array_model

// *** testbench/self_write_memory_control_test.sv ***
// Self-checking bench for the self-write memory control block.
// Assumes the array model answers combinationally and PROG_CYCLES is cut to 8.
`timescale 1ns/10ps
module self_write_memory_control_test;
   localparam logic [nvm_ctrl_pkg::CNT_W-1:0] PROG = 17'h00008;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [15:0] flash_word_i;
   logic [7:0] eeprom_byte_i;
   logic master_clear_reset_i = 1'b0;
   logic watchdog_reset_i = 1'b0;
   nvm_ctrl_pkg::nv_cmd_t nv_cmd_o;
   logic cpu_stall_o;
   logic nonvolatile_done_irq_flag_o;
   int n_fail = 0;
   int checks_done = 0;
   logic [31:0] exp_q[$];
   string name_q[$];
   logic [21:0] p, acc, nxt;
   logic [7:0] bb, ea;
   logic [2:0] ix;
   logic [63:0] wexp;
   nvm_ctrl_pkg::nv_cmd_t cmd_seen;

   // Core clock at 50 MHz.
   always #10 clk_i = ~clk_i;

   nvm_access_ctrl #(.PROG_CYCLES(PROG)) u_nvm_access_ctrl (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .flash_word_i(flash_word_i), .eeprom_byte_i(eeprom_byte_i),
      .master_clear_reset_i(master_clear_reset_i), .watchdog_reset_i(watchdog_reset_i),
      .nv_cmd_o(nv_cmd_o), .cpu_stall_o(cpu_stall_o),
      .nonvolatile_done_irq_flag_o(nonvolatile_done_irq_flag_o));

   nvm_array_model u_nvm_array_model (.cmd_i(nv_cmd_o), .flash_word_o(flash_word_i),
      .eeprom_byte_o(eeprom_byte_i));

   task automatic finish_test();
      if (n_fail == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One classic cycle; the request is held until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 400);
      cmd_seen = nv_cmd_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 400) begin
         chk("bus ack", 64'h1, 64'h0);
         finish_test();
      end
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, {24'h000000, d});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      exp_q.push_back({24'h000000, e});
      name_q.push_back(nm);
      wb(1'b0, a, 32'h00000000);
   endtask : rd

   task automatic setp(input logic [21:0] v);
      wr(nvm_ctrl_pkg::OFF_PTR_U, {2'b00, v[21:16]});
      wr(nvm_ctrl_pkg::OFF_PTR_H, v[15:8]);
      wr(nvm_ctrl_pkg::OFF_PTR_L, v[7:0]);
   endtask : setp

   task automatic rdp(input logic [21:0] v);
      rd(nvm_ctrl_pkg::OFF_PTR_U, {2'b00, v[21:16]}, "ptr upper");
      rd(nvm_ctrl_pkg::OFF_PTR_H, v[15:8], "ptr high");
      rd(nvm_ctrl_pkg::OFF_PTR_L, v[7:0], "ptr low");
   endtask : rdp

   // Control byte, unlock keys, then the same control byte with the launch bit added.
   task automatic launch(input logic [7:0] c);
      wr(nvm_ctrl_pkg::OFF_CTRL, c);
      wr(nvm_ctrl_pkg::OFF_UNLOCK, nvm_ctrl_pkg::UNLOCK_KEY1);
      wr(nvm_ctrl_pkg::OFF_UNLOCK, nvm_ctrl_pkg::UNLOCK_KEY2);
      wr(nvm_ctrl_pkg::OFF_CTRL, c | 8'h02);
   endtask : launch

   task automatic wait_done();
      int n = 0;
      while (nonvolatile_done_irq_flag_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk("done flag", 64'h1, 64'(nonvolatile_done_irq_flag_o));
      chk("cycle length", 64'(PROG), 64'(n));
      if (n >= 400) begin
         finish_test();
      end
      rd(nvm_ctrl_pkg::OFF_DONE, 8'h01, "done sticky");
      wr(nvm_ctrl_pkg::OFF_DONE, 8'h00);
      rd(nvm_ctrl_pkg::OFF_DONE, 8'h00, "done cleared");
   endtask : wait_done

   function automatic logic [7:0] fb(input logic [21:0] a);
      return a[0] ? a[8:1] ^ 8'h5A : {a[21] ^ a[16], a[15:9]};
   endfunction : fb

   // Takes the oldest expected read value whenever a read is answered.
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         chk(name_q.pop_front(), {32'h0, exp_q.pop_front()}, {32'h0, wb_dat_o});
      end
   end

   // Main sequence: registers, table ops, long writes, refusals and aborts.
   initial begin
      void'($urandom(11498));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h00, "ctrl reset");
      wr(nvm_ctrl_pkg::OFF_UNLOCK, 8'hFF);
      rd(nvm_ctrl_pkg::OFF_UNLOCK, 8'h00, "unlock port");
      rd(8'h30, 8'h00, "unmapped");
      wr(nvm_ctrl_pkg::OFF_CTRL, 8'hE4);
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'hC4, "ctrl fields");
      wr(nvm_ctrl_pkg::OFF_CTRL, 8'h00);
      bb = 8'($urandom);
      wr(nvm_ctrl_pkg::OFF_LATCH, bb);
      rd(nvm_ctrl_pkg::OFF_LATCH, bb, "latch rw");
      setp(22'h3FFFFF);
      rdp(22'h3FFFFF);
      for (int m = 0; m < 4; m++) begin
         p = (m == 1) ? 22'h3FFFFF : (m == 2) ? 22'h200000 : 22'($urandom);
         acc = (m == 3) ? {p[21], p[20:0] + 21'h1} : p;
         nxt = (m == 0) ? p : (m == 2) ? {p[21], p[20:0] - 21'h1} : {p[21], p[20:0] + 21'h1};
         setp(p);
         wr(nvm_ctrl_pkg::OFF_TBL_OP, {6'h00, 2'(m)});
         rd(nvm_ctrl_pkg::OFF_LATCH, fb(acc), "fetched byte");
         chk("fetch addr", 64'(acc), 64'(nv_cmd_o.addr));
         rdp(nxt);
      end
      p = {2'b00, 20'($urandom)};
      setp(p);
      for (int k = 0; k < 8; k++) begin
         bb = 8'($urandom);
         ix = p[2:0] + 3'(k);
         wexp[{ix, 3'h0} +: 8] = bb;
         wr(nvm_ctrl_pkg::OFF_LATCH, bb);
         wr(nvm_ctrl_pkg::OFF_TBL_OP, 8'h05);
      end
      p = p + 22'h8;
      launch(8'h84);
      chk("prog start", 64'h1, 64'(cmd_seen.prog_start));
      chk("prog addr", 64'({p[21:3], 3'h0}), 64'(nv_cmd_o.addr));
      chk("prog data", wexp, nv_cmd_o.wdata);
      chk("prog space", 64'(nvm_ctrl_pkg::SPACE_FLASH), 64'(nv_cmd_o.space));
      chk("prog stall", 64'h1, 64'(cpu_stall_o));
      wait_done();
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h84, "wr cleared");
      p = 22'($urandom);
      setp(p);
      launch(8'h94);
      chk("erase start", 64'h1, 64'(cmd_seen.erase_start));
      chk("erase addr", 64'({p[21:6], 6'h00}), 64'(nv_cmd_o.addr));
      wait_done();
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h84, "erase cleared");
      launch(8'h80);
      chk("no permit", 64'h0, 64'(cmd_seen.prog_start));
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h80, "refused wr");
      wr(nvm_ctrl_pkg::OFF_CTRL, 8'h84);
      wr(nvm_ctrl_pkg::OFF_CTRL, 8'h86);
      chk("no unlock", 64'h0, 64'(cmd_seen.prog_start));
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h84, "locked wr");
      ea = 8'($urandom);
      wr(nvm_ctrl_pkg::OFF_EE_ADDR, ea);
      wr(nvm_ctrl_pkg::OFF_CTRL, 8'h01);
      chk("ee read", 64'h1, 64'(cmd_seen.ee_read));
      rd(nvm_ctrl_pkg::OFF_EE_DATA, ea ^ 8'hC3, "ee data");
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h00, "rd cleared");
      wr(nvm_ctrl_pkg::OFF_CTRL, 8'h81);
      chk("flash rd", 64'h0, 64'(cmd_seen.ee_read));
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h80, "rd refused");
      launch(8'hC4);
      chk("cfg space", 64'(nvm_ctrl_pkg::SPACE_CONFIG), 64'(nv_cmd_o.space));
      @(posedge clk_i);
      watchdog_reset_i <= 1'b1;
      @(posedge clk_i);
      watchdog_reset_i <= 1'b0;
      @(posedge clk_i);
      chk("abort pulse", 64'h1, 64'(nv_cmd_o.abort));
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'hC8, "wdt abort");
      launch(8'h04);
      chk("ee space", 64'(nvm_ctrl_pkg::SPACE_EEPROM), 64'(nv_cmd_o.space));
      @(posedge clk_i);
      master_clear_reset_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      master_clear_reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h08, "master_clear_reset abort");
      launch(8'h0C);
      wait_done();
      rd(nvm_ctrl_pkg::OFF_CTRL, 8'h04, "werr cleared");
      finish_test();
   end
endmodule : self_write_memory_control_test
